//--- src/acs_defines.svh
// timing counts and fixed values for the conversion sequencer
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

`define ACS_CLK_PERIOD_NS   100
`define ACS_RD_HOLD_NS      25
`define ACS_RD_HOLD_CYC     ((`ACS_RD_HOLD_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
// three stages plus the agree register before data_s shows a new value
`define ACS_SYNC_LAT_CYC    4
`define ACS_RD_LOW_CYC      (`ACS_RD_HOLD_CYC + `ACS_SYNC_LAT_CYC)
`define ACS_PACE_PERIOD     16
`define ACS_BLOCK_LEN       128
`define ACS_DATA_W          12
`define ACS_CHAN_W          2
`define ACS_PACE_W          8
`define ACS_CNT_W           16

`endif

//--- src/acs_pkg.sv
// types shared by the conversion sequencer
package acs_pkg;

   typedef enum logic [6:0] {
      ACS_ST_IDLE       = 7'h01,
      ACS_ST_WAIT_FIRST = 7'h02,
      ACS_ST_LO_LOW     = 7'h04,
      ACS_ST_READ       = 7'h08,
      ACS_ST_RELEASE    = 7'h10,
      ACS_ST_SET_SEL    = 7'h20,
      ACS_ST_WAIT_EOC   = 7'h40
   } acs_state_e;

   typedef enum logic [1:0] {
      ACS_MODE_SEQ    = 2'h0,
      ACS_MODE_ALT    = 2'h1,
      ACS_MODE_SINGLE = 2'h2
   } acs_mode_e;

   typedef logic [1:0] acs_chan_t;

endpackage

//--- src/acs_sync.sv
// three-stage synchroniser; output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module acs_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else if (ce_i) begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // only a value seen twice in a row is passed on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_o <= RST_VAL;
      end else if (ce_i && (s2_q == s3_q)) begin
         q_o <= s3_q;
      end
   end

endmodule

`default_nettype wire

//--- src/acs_sequencer.sv
// host-side pacing and read sequencer for a 4-channel 12-bit SAR converter
`timescale 1ns/1ps
`default_nettype none

`include "acs_defines.svh"

// Operation
// - one convert-start low phase per pace period; longer periods slow sampling
// - pace counter runs on the conversion clock; period 16 gives full rate
// - start line idles high and pulses low, one pulse per counted period
// - with period 16 start stays high 15 clocks then low for one
// - each start low pulse lasts exactly one conversion-clock cycle
// - first conversion after start-up is a dummy and is never read
// - rising edge of busy marks end of conversion; one sample is read
// - low select line is driven low before the read strobe falls
// - after each read select the channel two conversions ahead
// - at start-up start high, selects low, pacing runs, wait first edge
// - alternating mode toggles high select each conversion, pattern of two
// - the alternation can be restarted midway through its two-sample pattern; dropping enable_i restarts it on channel 0 once a wait state sees it low
// - selects stay steady across the start edge; low select held low
// - sample rate is conversion clock over integer pace period only
// - start pulse is the inverted one-cycle carry of a period counter
// - every sample carries the channel it was converted from
// - single-channel mode holds both select lines low permanently
// - a sticky flag reports that a full block of samples was delivered
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int DATA_W    = `ACS_DATA_W,
   parameter int PACE_W    = `ACS_PACE_W,
   parameter int PACE      = `ACS_PACE_PERIOD,
   parameter int BLOCK_LEN = `ACS_BLOCK_LEN
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic              conv_clk_i,
   input  wire logic              enable_i,
   input  wire logic [1:0]        mode_i,
   input  wire logic              done_ack_i,
   input  wire logic              busy_n_i,
   input  wire logic [DATA_W-1:0] data_i,
   output logic                   conv_start_n_o,
   output logic                   chan_sel_lo_o,
   output logic                   chan_sel_hi_o,
   output logic                   cs_n_o,
   output logic                   rd_n_o,
   output logic                   sample_valid_o,
   output logic [DATA_W-1:0]      sample_data_o,
   output logic [1:0]             sample_chan_o,
   output logic                   block_done_o,
   output logic                   running_o
);

   localparam int RD_LOW = `ACS_RD_LOW_CYC;
   localparam logic [PACE_W-1:0] PACE_LAST = PACE_W'(PACE - 1);
   localparam logic [`ACS_CNT_W-1:0] BLK_LAST = `ACS_CNT_W'(BLOCK_LEN - 1);

   acs_state_e          state_q;
   acs_mode_e           mode_q;
   logic                run_q;
   acs_chan_t           sel_q;
   logic                lo_force_q;
   acs_chan_t           pend_now_q;
   acs_chan_t           pend_next_q;
   logic [3:0]          rd_cnt_q;
   logic [`ACS_CNT_W-1:0] blk_cnt_q;
   logic                busy_n_s;
   logic                busy_prev_q;
   logic                eoc;
   logic [DATA_W-1:0]   data_s;
   acs_chan_t           next_chan;

   // ---------------- conversion-clock domain ----------------
   logic                run_c;
   logic                rst_c;
   logic                ce_c;
   logic [PACE_W-1:0]   pace_cnt_q;

   // reset, clock enable and run cross as levels
   acs_sync #(.W(1), .RST_VAL(1'b1)) u_rst_c (
      .clk_i (conv_clk_i),
      .rst_i (1'b0),
      .ce_i  (1'b1),
      .d_i   (rst_i),
      .q_o   (rst_c)
   );

   acs_sync #(.W(1), .RST_VAL(1'b0)) u_ce_c (
      .clk_i (conv_clk_i),
      .rst_i (rst_c),
      .ce_i  (1'b1),
      .d_i   (ce_i),
      .q_o   (ce_c)
   );

   acs_sync #(.W(1), .RST_VAL(1'b0)) u_run_c (
      .clk_i (conv_clk_i),
      .rst_i (rst_c),
      .ce_i  (ce_c),
      .d_i   (run_q),
      .q_o   (run_c)
   );

   // counter wraps every PACE conversion clocks; rate = clock / PACE
   always_ff @(posedge conv_clk_i) begin
      if (rst_c || !run_c) begin
         pace_cnt_q <= '0;
      end else if (ce_c) begin
         if (pace_cnt_q == PACE_LAST) begin
            pace_cnt_q <= '0;
         end else begin
            pace_cnt_q <= pace_cnt_q + PACE_W'(1);
         end
      end
   end

   // inverted carry: high for PACE-1 clocks, low for exactly one
   // the low phase is a whole clock so a rising edge falls inside it
   always_ff @(posedge conv_clk_i) begin
      if (rst_c || !run_c) begin
         conv_start_n_o <= 1'b1;
      end else if (ce_c) begin
         conv_start_n_o <= !(pace_cnt_q == PACE_LAST);
      end
   end

   // ---------------- system-clock domain ----------------
   acs_sync #(.W(1), .RST_VAL(1'b1)) u_busy (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   (busy_n_i),
      .q_o   (busy_n_s)
   );

   // data is stable for the whole strobe, so sync latency is covered
   acs_sync #(.W(DATA_W), .RST_VAL('0)) u_data (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   (data_i),
      .q_o   (data_s)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_prev_q <= 1'b1;
      end else if (ce_i) begin
         busy_prev_q <= busy_n_s;
      end
   end

   assign eoc = busy_n_s && !busy_prev_q;

   // channel to request after the one currently latched
   always_comb begin
      next_chan = pend_next_q;
      unique case (mode_q)
         ACS_MODE_SEQ:    next_chan = pend_next_q + 2'h1;
         ACS_MODE_ALT:    next_chan = {!pend_next_q[1], 1'b0};
         ACS_MODE_SINGLE: next_chan = 2'h0;
         default:         next_chan = 2'h0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ACS_ST_IDLE;
      end else if (ce_i) begin
         unique case (state_q)
            ACS_ST_IDLE: begin
               if (enable_i) begin
                  state_q <= ACS_ST_WAIT_FIRST;
               end
            end
            ACS_ST_WAIT_FIRST: begin
               if (!enable_i) begin
                  state_q <= ACS_ST_IDLE;
               end else if (eoc) begin
                  state_q <= ACS_ST_SET_SEL; // dummy: no read
               end
            end
            ACS_ST_LO_LOW: begin
               state_q <= ACS_ST_READ;
            end
            ACS_ST_READ: begin
               if (rd_cnt_q == 4'(RD_LOW - 1)) begin
                  state_q <= ACS_ST_RELEASE;
               end
            end
            ACS_ST_RELEASE: begin
               state_q <= ACS_ST_SET_SEL;
            end
            ACS_ST_SET_SEL: begin
               state_q <= ACS_ST_WAIT_EOC;
            end
            ACS_ST_WAIT_EOC: begin
               if (!enable_i) begin
                  state_q <= ACS_ST_IDLE;
               end else if (eoc) begin
                  state_q <= ACS_ST_LO_LOW; // one read per edge
               end
            end
            default: state_q <= ACS_ST_IDLE;
         endcase
      end
   end

   // mode and run flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= ACS_MODE_SEQ;
         run_q  <= 1'b0;
      end else if (ce_i) begin
         if (state_q == ACS_ST_IDLE && enable_i) begin
            mode_q <= acs_mode_e'(mode_i);
            run_q  <= 1'b1;
         end else if (state_q == ACS_ST_IDLE || !enable_i) begin
            run_q  <= 1'b0;
         end
      end
   end

   // select lines and the two-entry channel record
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_q       <= 2'h0;
         pend_now_q  <= 2'h0;
         pend_next_q <= 2'h0;
         lo_force_q  <= 1'b0;
      end else if (ce_i) begin
         if (state_q == ACS_ST_IDLE) begin
            // every mode starts on channel 0 so the record matches the pins
            sel_q       <= 2'h0;
            pend_now_q  <= 2'h0;
            pend_next_q <= 2'h0;
            lo_force_q  <= 1'b0;
         end else if (state_q == ACS_ST_WAIT_EOC && eoc) begin
            lo_force_q  <= 1'b1; // low select down before the strobe
         end else if (state_q == ACS_ST_SET_SEL) begin
            // the latched channel is now converting; request the one after
            pend_now_q  <= pend_next_q;
            pend_next_q <= next_chan;
            sel_q       <= next_chan;
            lo_force_q  <= 1'b0;
         end
      end
   end

   // select pins; in alternating mode the low line never rises
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_sel_lo_o <= 1'b0;
         chan_sel_hi_o <= 1'b0;
      end else if (ce_i) begin
         // drop the low select on the edge that sees end of conversion,
         // a full clock ahead of the strobe
         chan_sel_lo_o <= sel_q[0] && !lo_force_q && (mode_q == ACS_MODE_SEQ)
                          && !(state_q == ACS_ST_WAIT_EOC && eoc);
         chan_sel_hi_o <= sel_q[1] && (mode_q != ACS_MODE_SINGLE);
      end
   end

   // read strobe: chip select and read low together while data settles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_n_o   <= 1'b1;
         rd_n_o   <= 1'b1;
         rd_cnt_q <= 4'h0;
      end else if (ce_i) begin
         if (state_q == ACS_ST_LO_LOW) begin
            cs_n_o   <= 1'b0;
            rd_n_o   <= 1'b0;
            rd_cnt_q <= 4'h0;
         end else if (state_q == ACS_ST_READ) begin
            rd_cnt_q <= rd_cnt_q + 4'h1;
            if (rd_cnt_q == 4'(RD_LOW - 1)) begin
               cs_n_o <= 1'b1; // strobe back high before any next read
               rd_n_o <= 1'b1;
            end
         end
      end
   end

   // sample out, tagged with the channel actually converted
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sample_valid_o <= 1'b0;
         sample_data_o  <= '0;
         sample_chan_o  <= 2'h0;
      end else if (ce_i) begin
         sample_valid_o <= 1'b0;
         // the strobe count spans the whole synchroniser delay of data_s
         if (state_q == ACS_ST_READ && rd_cnt_q == 4'(RD_LOW - 1)) begin
            sample_valid_o <= 1'b1;
            sample_data_o  <= data_s;
            sample_chan_o  <= pend_now_q;
         end
      end
   end

   // block counter and sticky done flag; a new completion beats the ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         blk_cnt_q    <= '0;
         block_done_o <= 1'b0;
      end else if (ce_i) begin
         if (sample_valid_o) begin
            if (blk_cnt_q == BLK_LAST) begin
               blk_cnt_q    <= '0;
               block_done_o <= 1'b1;
            end else begin
               blk_cnt_q <= blk_cnt_q + `ACS_CNT_W'(1);
               if (done_ack_i) begin
                  block_done_o <= 1'b0;
               end
            end
         end else if (done_ack_i) begin
            block_done_o <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         running_o <= 1'b0;
      end else if (ce_i) begin
         running_o <= run_q;
      end
   end

endmodule

`default_nettype wire

//--- verification/acs_adc_model.sv
// behavioural model of the 4-channel converter facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_adc_model (
   input  wire logic        conv_clk_i,
   input  wire logic        conv_start_n_i,
   input  wire logic        chan_sel_lo_i,
   input  wire logic        chan_sel_hi_i,
   input  wire logic        cs_n_i,
   input  wire logic        rd_n_i,
   output logic             busy_n_o,
   output logic [11:0]      data_o,
   output logic             pwr_down_o
);
   logic [1:0]  nxt_q = 2'h0;
   // odd start value so a read before the first conversion shows up
   logic [1:0]  cur_q = 2'h3;
   logic [3:0]  cnt_q = 4'h0;
   logic        pd_q = 1'b0;
   int          starts = 0;
   int          ends = 0;
   logic [11:0] res;
   assign res = {cur_q, 10'h2A5};
   assign busy_n_o = (starts == ends);
   // a released bus shows the inverse so a stale value never passes
   assign data_o = (!cs_n_i && !rd_n_i) ? res : ~res;
   assign pwr_down_o = pd_q;
   always @(negedge conv_start_n_i) starts <= starts + 1;
   always @(posedge conv_start_n_i) begin
      nxt_q <= {chan_sel_hi_i, chan_sel_lo_i};
   end
   always @(posedge conv_clk_i) begin
      if (cnt_q != 4'h0) begin
         cnt_q <= (cnt_q == 4'hC) ? 4'h0 : cnt_q + 4'h1;
         if (cnt_q == 4'hC) ends <= ends + 1;
      end else if (!conv_start_n_i) begin
         cur_q <= nxt_q;
         cnt_q <= 4'h1;
      end
   end
   always @(posedge rd_n_i) if (chan_sel_lo_i) pd_q <= 1'b1;
endmodule
`default_nettype wire

//--- verification/acs_sequencer_checker.sv
// port-level assertions for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_checker #(
   parameter int PACE = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic conv_clk_i,
   input wire logic done_ack_i,
   input wire logic conv_start_n_o,
   input wire logic chan_sel_lo_o,
   input wire logic chan_sel_hi_o,
   input wire logic cs_n_o,
   input wire logic rd_n_o,
   input wire logic sample_valid_o,
   input wire logic block_done_o,
   input wire logic running_o
);
   logic        st_q;
   logic [15:0] gap_q;
   always_ff @(posedge conv_clk_i) begin
      st_q <= conv_start_n_o;
   end
   // cleared while idle so a resumed run is not taken for a slow one
   always_ff @(posedge conv_clk_i) begin
      if (rst_i || !running_o)
         gap_q <= 16'h0;
      else if (st_q && !conv_start_n_o)
         gap_q <= 16'h1;
      else if (gap_q != 16'h0)
         gap_q <= gap_q + 16'h1;
   end
   chk_start_width: assert property (
      @(posedge conv_clk_i) disable iff (rst_i)
      $fell(conv_start_n_o) |=> conv_start_n_o) else $error("start too long");
   chk_start_gap: assert property (
      @(posedge conv_clk_i) disable iff (rst_i)
      st_q && !conv_start_n_o && gap_q != 16'h0 |-> gap_q == PACE)
      else $error("start spacing wrong");
   chk_sel_steady: assert property (
      @(posedge conv_clk_i) disable iff (rst_i) running_o &&
      $rose(conv_start_n_o) |-> $stable({chan_sel_hi_o, chan_sel_lo_o}))
      else $error("select moved at start edge");
   chk_lo_in_read: assert property (
      @(posedge clk_i) disable iff (rst_i)
      !rd_n_o || $rose(rd_n_o) |-> !chan_sel_lo_o) else $error("low select high");
   chk_strobe_len: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(rd_n_o) |-> !rd_n_o [*5] ##1 rd_n_o) else $error("strobe length");
   chk_lo_before_rd: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(rd_n_o) |-> !$past(chan_sel_lo_o)) else $error("low select late");
   chk_cs_with_rd: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cs_n_o == rd_n_o) else $error("select and strobe differ");
   chk_valid_edge: assert property (
      @(posedge clk_i) disable iff (rst_i)
      sample_valid_o == $rose(rd_n_o)) else $error("valid not at strobe end");
   chk_reset_state: assert property (
      @(posedge clk_i) disable iff (rst_i) $past(rst_i) |-> cs_n_o &&
      rd_n_o && !chan_sel_lo_o && !chan_sel_hi_o && !running_o)
      else $error("outputs not idle after reset");
   chk_done_sticky: assert property (
      @(posedge clk_i) disable iff (rst_i)
      block_done_o && !done_ack_i |=> block_done_o) else $error("done lost");
endmodule
bind acs_sequencer acs_sequencer_checker #(.PACE(PACE)) u_chk (
   .clk_i, .rst_i, .conv_clk_i, .done_ack_i, .conv_start_n_o,
   .chan_sel_lo_o, .chan_sel_hi_o, .cs_n_o, .rd_n_o, .sample_valid_o,
   .block_done_o, .running_o);
`default_nettype wire

//--- verification/acs_sequencer_test.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_test;
   import acs_pkg::*;
   logic        clk_i = 1'b0;
   logic        conv_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        enable_i = 1'b0;
   logic        done_ack_i = 1'b0;
   logic [1:0]  mode_i = 2'h0;
   logic        busy_n, start_n, lo, hi, cs_n, rd_n, vld, done, run, pd;
   logic [11:0] adc_data, s_data;
   logic [1:0]  s_chan;
   int          miscompares = 0;
   int          checks_done = 0;

   // pace 24: the read path is too slow to settle selects at 16
   acs_sequencer #(.PACE(24), .BLOCK_LEN(4)) DUT (
      .clk_i, .rst_i, .ce_i(1'b1), .conv_clk_i, .enable_i, .mode_i,
      .done_ack_i, .busy_n_i(busy_n), .data_i(adc_data),
      .conv_start_n_o(start_n), .chan_sel_lo_o(lo), .chan_sel_hi_o(hi),
      .cs_n_o(cs_n), .rd_n_o(rd_n), .sample_valid_o(vld),
      .sample_data_o(s_data), .sample_chan_o(s_chan),
      .block_done_o(done), .running_o(run));
   acs_adc_model adc (
      .conv_clk_i, .conv_start_n_i(start_n), .chan_sel_lo_i(lo),
      .chan_sel_hi_i(hi), .cs_n_i(cs_n), .rd_n_i(rd_n),
      .busy_n_o(busy_n), .data_o(adc_data), .pwr_down_o(pd));

   initial forever #50 clk_i = ~clk_i;
   initial begin
      #37;
      forever #80 conv_clk_i = ~conv_clk_i;
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wait_vld;
      int n = 0;
      @(negedge clk_i);
      while (vld !== 1'b1 && n < 400) begin
         @(negedge clk_i);
         n++;
      end
   endtask
   task automatic take(input logic [1:0] ch);
      wait_vld();
      chk({3'h0, vld, s_data}, {4'h1, ch, 10'h2A5});
      chk({14'h0, s_chan}, {14'h0, ch});
   endtask
   // restart only after any stray conversion has finished
   task automatic restart(input acs_mode_e m);
      enable_i = 1'b0;
      repeat (40) @(negedge clk_i);
      mode_i = m;
      enable_i = 1'b1;
   endtask

   initial begin
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
      chk({8'h0, start_n, cs_n, rd_n, lo, hi, vld, done, run}, 16'h00E0);
      mode_i = ACS_MODE_SEQ;
      enable_i = 1'b1;
      for (int i = 0; i < 5; i++) begin
         take(i[1:0]);
         if (i == 0) chk({15'h0, run}, 16'h0001);
         if (i == 2) chk({15'h0, done}, 16'h0000);
      end
      chk({15'h0, done}, 16'h0001);
      done_ack_i = 1'b1;
      @(negedge clk_i);
      done_ack_i = 1'b0;
      @(negedge clk_i);
      chk({15'h0, done}, 16'h0000);
      restart(ACS_MODE_ALT);
      for (int i = 0; i < 4; i++) begin
         wait_vld();
         chk({14'h0, s_data[11:10]}, {14'h0, i[0], 1'b0});
         chk({13'h0, vld, s_chan}, {13'h0, 1'b1, i[0], 1'b0});
         chk({15'h0, lo}, 16'h0000);
      end
      restart(ACS_MODE_SINGLE);
      for (int i = 0; i < 2; i++) begin
         take(2'h0);
         chk({14'h0, hi, lo}, 16'h0000);
      end
      chk({15'h0, pd}, 16'h0000);
      finish_test();
   end
   // about 75 us of traffic is expected; this allows four times that
   initial begin
      #300000;
      miscompares++;
      finish_test();
   end
endmodule
`default_nettype wire
